// file: adc_seq_pkg.sv
// Shared constants, types and register map of the conversion sequencer.
package adc_seq_pkg;

  // ********************************************************************
  // Register map and fields
  // ********************************************************************
  localparam logic [15:0] RESULT_OFS = 16'hFEA0;
  localparam logic [15:0] CONTROL_OFS = 16'hFFA0;
  localparam logic [15:0] STATUS_OFS = 16'hFFA4;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 8;
  localparam int EOC_BIT = 0;
  localparam int OVR_BIT = 1;
  localparam int PORT_LSB = 16;
  localparam logic [3:0] LAST_CHANNEL = 4'h9;
  localparam logic [3:0] CHANNEL_ZERO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam real CLK_MHZ = 50.0;
  localparam real SAMPLE_TIME_US = 1.575;
  localparam real CONVERT_TIME_US = 8.175;
  localparam int SAMPLE_CYC = int'($ceil(SAMPLE_TIME_US * CLK_MHZ));
  localparam int CONVERT_CYC = int'($ceil(CONVERT_TIME_US * CLK_MHZ));

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_SINGLE_REPEAT,
    MODE_SCAN_ONCE,
    MODE_SCAN_REPEAT
  } conv_mode_e;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;

  typedef struct packed {
    logic start;
    logic rsvd;
    conv_mode_e mode;
    logic [3:0] channel;
  } ctrl_s;

  typedef struct packed {
    logic [3:0] channel;
    logic [1:0] rsvd;
    logic [9:0] value;
  } result_s;

endpackage : adc_seq_pkg

// file: phase_timer.sv
// Down counter that times one phase of a conversion.
`timescale 1ns/100ps
module phase_timer #(
  parameter int W = 9
) (
  input wire logic clk_in, // System clock.
  input wire logic srst_in, // Synchronous reset, high.
  input wire logic load_in, // Start a new phase.
  input wire logic [W-1:0] load_value_in, // Phase length minus one.
  output logic expired_out // Last cycle of the phase.
);
  logic [W-1:0] count_ff;
  logic running_ff;

  assign expired_out = running_ff && (count_ff == '0);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      count_ff <= '0;
      running_ff <= 1'b0;
    end
    else if (load_in)
    begin
      count_ff <= load_value_in;
      running_ff <= 1'b1;
    end
    else if (expired_out)
      running_ff <= 1'b0;
    else if (running_ff)
      count_ff <= count_ff - 1'b1;
  end
endmodule : phase_timer

// file: adc_conversion_sequencer.sv
// Conversion sequencer for a 10-channel converter with AXI4-Lite access.
//
// Summary of operation
// - Mode field picks one of four modes.
// - Channels 0 to 9 valid, others invalid.
// - Channel field is first or only channel.
// - Result holds value low, channel top.
// - Result stays until next completed conversion.
// - Writing start begins conversion, sets busy.
// - Sample phase then convert phase, timed.
// - Completion stores result, sets end request.
// - Unread result at completion sets overrun.
// - Start cleared then set aborts, restarts.
// - Mode change applies from next conversion.
// - Channel change applies next conversion or round.
// - Single mode converts once, then stops.
// - Single mode ignores start clear meanwhile.
// - Busy is read-only, shows conversion running.
// - Input lines need no configuration.
// - Single repeat runs until start cleared.
// - Scan once counts down to zero, stops.
// - Scan repeat reloads, finishes round on stop.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module adc_conversion_sequencer #(
  parameter int TIMER_W = 9
) (
  input wire logic clk_in, // System clock.
  input wire logic srst_in, // Synchronous reset, high.
  input wire logic [15:0] axi_awaddr_in, // Write address.
  input wire logic axi_awvalid_in, // Write address valid.
  output logic axi_awready_out, // Write address ready.
  input wire logic [31:0] axi_wdata_in, // Write data.
  input wire logic [3:0] axi_wstrb_in, // Write byte strobes.
  input wire logic axi_wvalid_in, // Write data valid.
  output logic axi_wready_out, // Write data ready.
  output logic [1:0] axi_bresp_out, // Write response.
  output logic axi_bvalid_out, // Write response valid.
  input wire logic axi_bready_in, // Write response ready.
  input wire logic [15:0] axi_araddr_in, // Read address.
  input wire logic axi_arvalid_in, // Read address valid.
  output logic axi_arready_out, // Read address ready.
  output logic [31:0] axi_rdata_out, // Read data.
  output logic [1:0] axi_rresp_out, // Read response.
  output logic axi_rvalid_out, // Read data valid.
  input wire logic axi_rready_in, // Read data ready.
  input wire logic [9:0] port_lines_in, // Input-only port levels.
  input wire logic [9:0] core_result_in, // Converter core output.
  output logic [3:0] mux_channel_out, // Multiplexer channel.
  output logic channel_valid_out, // Multiplexer selects a channel.
  output logic sample_out, // Sample-and-hold tracking.
  output logic convert_out // Held level being converted.
);
  localparam logic [TIMER_W-1:0] SAMPLE_LOAD =
    TIMER_W'(adc_seq_pkg::SAMPLE_CYC - 1);
  localparam logic [TIMER_W-1:0] CONVERT_LOAD =
    TIMER_W'(adc_seq_pkg::CONVERT_CYC - 1);

  // ********************************************************************
  // Bus slave
  // ********************************************************************
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_held_ff, w_held_ff;
  logic [15:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_do, wr_ctrl, wr_stat, rd_take, rd_result;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;
  adc_seq_pkg::ctrl_s wd;

  assign wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wd = adc_seq_pkg::ctrl_s'(wdata_ff[7:0]);
  assign wr_ctrl = wr_do && wstrb_ff[0] &&
    (awaddr_ff == adc_seq_pkg::CONTROL_OFS);
  assign wr_stat = wr_do && wstrb_ff[0] &&
    (awaddr_ff == adc_seq_pkg::STATUS_OFS);
  assign rd_take = axi_arvalid_in && arready_ff;
  assign rd_result = rd_take && (axi_araddr_in == adc_seq_pkg::RESULT_OFS);

  // Address and data are held separately so either may come first.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      awaddr_ff <= 16'h0000;
    end
    else if (axi_awvalid_in && awready_ff)
    begin
      awaddr_ff <= axi_awaddr_in;
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
    end
    else if (wr_do)
      aw_held_ff <= 1'b0;
    else if (!aw_held_ff && !bvalid_ff)
      awready_ff <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (axi_wvalid_in && wready_ff)
    begin
      wdata_ff <= axi_wdata_in;
      wstrb_ff <= axi_wstrb_in;
      w_held_ff <= 1'b1;
      wready_ff <= 1'b0;
    end
    else if (wr_do)
      w_held_ff <= 1'b0;
    else if (!w_held_ff && !bvalid_ff)
      wready_ff <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= adc_seq_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == adc_seq_pkg::RESULT_OFS ||
        awaddr_ff == adc_seq_pkg::CONTROL_OFS ||
        awaddr_ff == adc_seq_pkg::STATUS_OFS) ?
        adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
    end
    else if (axi_bready_in)
      bvalid_ff <= 1'b0;
  end

  // ********************************************************************
  // Control and status state
  // ********************************************************************
  adc_seq_pkg::ctrl_s ctrl_ff;
  adc_seq_pkg::result_s result_ff;
  adc_seq_pkg::seq_state_e state_ff, nxt_state;
  adc_seq_pkg::conv_mode_e act_mode_ff, nxt_mode;
  logic [3:0] act_chan_ff, nxt_chan;
  logic busy_ff, eoc_ff, ovr_ff, unread_ff;
  logic sample_ff, convert_ff, chan_valid_ff;
  logic start_evt, expired, conv_done, go_on, hw_clear, tmr_load;

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = adc_seq_pkg::RESP_OKAY;
    unique case (axi_araddr_in)
      adc_seq_pkg::RESULT_OFS:
        nxt_rdata[15:0] = result_ff;
      adc_seq_pkg::CONTROL_OFS:
      begin
        nxt_rdata[7:0] = {ctrl_ff.start, 1'b0, ctrl_ff.mode, ctrl_ff.channel};
        nxt_rdata[adc_seq_pkg::BUSY_BIT] = busy_ff;
      end
      adc_seq_pkg::STATUS_OFS:
      begin
        nxt_rdata[adc_seq_pkg::EOC_BIT] = eoc_ff;
        nxt_rdata[adc_seq_pkg::OVR_BIT] = ovr_ff;
        nxt_rdata[adc_seq_pkg::PORT_LSB +: 10] = port_lines_in;
      end
      default:
        nxt_rresp = adc_seq_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= adc_seq_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
    else if (rvalid_ff && axi_rready_in)
      rvalid_ff <= 1'b0;
    else if (!rvalid_ff)
      arready_ff <= 1'b1;
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  // start request
  // Start only on a 0 to 1 of the bit, so rewriting 1 restarts nothing.
  assign start_evt = wr_ctrl && wd.start && !ctrl_ff.start;
  assign conv_done = (state_ff == adc_seq_pkg::ST_CONVERT) && expired;

  always_comb
  begin
    go_on = 1'b0;
    hw_clear = 1'b0;
    nxt_state = state_ff;
    nxt_mode = act_mode_ff;
    nxt_chan = act_chan_ff;
    tmr_load = 1'b0;
    unique case (act_mode_ff)
      adc_seq_pkg::MODE_SINGLE:
        hw_clear = 1'b1;
      adc_seq_pkg::MODE_SINGLE_REPEAT:
        go_on = ctrl_ff.start;
      adc_seq_pkg::MODE_SCAN_ONCE:
      begin
        go_on = act_chan_ff != adc_seq_pkg::CHANNEL_ZERO;
        hw_clear = !go_on;
      end
      adc_seq_pkg::MODE_SCAN_REPEAT:
        go_on = act_chan_ff != adc_seq_pkg::CHANNEL_ZERO || ctrl_ff.start;
    endcase
    hw_clear = hw_clear && conv_done && !start_evt;
    if (start_evt)
    begin
      nxt_state = adc_seq_pkg::ST_SAMPLE;
      nxt_mode = wd.mode;
      nxt_chan = wd.channel;
      tmr_load = 1'b1;
    end
    else if (state_ff == adc_seq_pkg::ST_SAMPLE && expired)
    begin
      nxt_state = adc_seq_pkg::ST_CONVERT;
      tmr_load = 1'b1;
    end
    else if (conv_done && go_on)
    begin
      nxt_state = adc_seq_pkg::ST_SAMPLE;
      nxt_mode = ctrl_ff.mode;
      tmr_load = 1'b1;
      if (ctrl_ff.mode[1] && act_mode_ff[1] &&
          act_chan_ff != adc_seq_pkg::CHANNEL_ZERO)
        nxt_chan = act_chan_ff - 4'h1;
      else
        nxt_chan = ctrl_ff.channel;
    end
    else if (conv_done)
      nxt_state = adc_seq_pkg::ST_IDLE;
  end

  phase_timer #(.W(TIMER_W)) phase_timer_i (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .load_in(tmr_load),
    .load_value_in(nxt_state == adc_seq_pkg::ST_SAMPLE ?
      SAMPLE_LOAD : CONVERT_LOAD),
    .expired_out(expired)
  );

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_ff <= adc_seq_pkg::ST_IDLE;
      act_mode_ff <= adc_seq_pkg::MODE_SINGLE;
      act_chan_ff <= 4'h0;
      busy_ff <= 1'b0;
      sample_ff <= 1'b0;
      convert_ff <= 1'b0;
      chan_valid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      act_mode_ff <= nxt_mode;
      act_chan_ff <= nxt_chan;
      busy_ff <= nxt_state != adc_seq_pkg::ST_IDLE;
      sample_ff <= nxt_state == adc_seq_pkg::ST_SAMPLE;
      convert_ff <= nxt_state == adc_seq_pkg::ST_CONVERT;
      chan_valid_ff <= nxt_state != adc_seq_pkg::ST_IDLE &&
        nxt_chan <= adc_seq_pkg::LAST_CHANNEL;
    end
  end

  // Software owns mode and channel; busy has no storage here.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      ctrl_ff <= adc_seq_pkg::ctrl_s'(adc_seq_pkg::CONTROL_RST[7:0]);
    else if (wr_ctrl)
    begin
      ctrl_ff <= wd;
      ctrl_ff.rsvd <= 1'b0;
      ctrl_ff.start <= wd.start && !(hw_clear && ctrl_ff.start);
    end
    else if (hw_clear)
      ctrl_ff.start <= 1'b0;
  end

  // An aborted conversion stores nothing.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      result_ff <= adc_seq_pkg::result_s'(adc_seq_pkg::RESULT_RST);
    else if (conv_done && !start_evt)
      result_ff <= {act_chan_ff, 2'h0, core_result_in};
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      eoc_ff <= 1'b0;
      ovr_ff <= 1'b0;
      unread_ff <= 1'b0;
    end
    else
    begin
      if (conv_done && !start_evt)
        eoc_ff <= 1'b1;
      else if (wr_stat && wdata_ff[adc_seq_pkg::EOC_BIT])
        eoc_ff <= 1'b0;
      if (conv_done && !start_evt && unread_ff)
        ovr_ff <= 1'b1;
      else if (wr_stat && wdata_ff[adc_seq_pkg::OVR_BIT])
        ovr_ff <= 1'b0;
      if (conv_done && !start_evt)
        unread_ff <= 1'b1;
      else if (rd_result)
        unread_ff <= 1'b0;
    end
  end

  assign axi_awready_out = awready_ff;
  assign axi_wready_out = wready_ff;
  assign axi_bvalid_out = bvalid_ff;
  assign axi_bresp_out = bresp_ff;
  assign axi_arready_out = arready_ff;
  assign axi_rvalid_out = rvalid_ff;
  assign axi_rdata_out = rdata_ff;
  assign axi_rresp_out = rresp_ff;
  assign mux_channel_out = act_chan_ff;
  assign channel_valid_out = chan_valid_ff;
  assign sample_out = sample_ff;
  assign convert_out = convert_ff;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  int phase_len_ff;
  always_ff @(posedge clk_in)
  begin
    if (srst_in || tmr_load)
      phase_len_ff <= 1;
    else
      phase_len_ff <= phase_len_ff + 1;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_start_sets_busy: assert property (
    start_evt |=> busy_ff && sample_out)
    else $error("start did not raise busy");
  a_sample_length: assert property (
    state_ff == adc_seq_pkg::ST_SAMPLE && !start_evt && expired
    |-> phase_len_ff == adc_seq_pkg::SAMPLE_CYC)
    else $error("sample phase length wrong");
  a_convert_length: assert property (
    conv_done && !start_evt |-> phase_len_ff == adc_seq_pkg::CONVERT_CYC)
    else $error("convert phase length wrong");
  a_result_stable: assert property (
    !conv_done |=> $stable(result_ff))
    else $error("result changed without a conversion");
  a_result_store: assert property (
    conv_done && !start_evt |=> result_ff.channel == $past(act_chan_ff)
    && eoc_ff)
    else $error("result or end request not stored");
  a_overrun_set: assert property (
    conv_done && !start_evt && unread_ff |=> ovr_ff)
    else $error("overrun not flagged");
  a_single_stops: assert property (
    conv_done && !start_evt && act_mode_ff == adc_seq_pkg::MODE_SINGLE
    |=> !busy_ff && !ctrl_ff.start)
    else $error("single mode did not stop");
  a_scan_steps_down: assert property (
    conv_done && !start_evt && act_mode_ff[1] && ctrl_ff.mode[1]
    && act_chan_ff != 4'h0 |=> mux_channel_out == $past(act_chan_ff) - 4'h1)
    else $error("scan did not step down");
  a_busy_matches: assert property (
    busy_ff == (sample_out || convert_out))
    else $error("busy differs from phase outputs");
  a_channel_held: assert property (
    convert_out && !tmr_load |=> $stable(mux_channel_out))
    else $error("channel changed mid conversion");

  c_overrun: cover property (conv_done && unread_ff);
  c_abort: cover property (start_evt && busy_ff);
  c_scan_reload: cover property (conv_done && go_on
    && act_mode_ff == adc_seq_pkg::MODE_SCAN_REPEAT && act_chan_ff == 4'h0);
  c_repeat_stop: cover property (conv_done && !go_on
    && act_mode_ff == adc_seq_pkg::MODE_SINGLE_REPEAT);

endmodule : adc_conversion_sequencer

// file: adc_core_model.sv
// Behavioural model of the multiplexer, sample-and-hold and converter core.
`timescale 1ns/100ps
module adc_core_model (
  input wire logic clk_in, // System clock.
  input wire logic srst_in, // Synchronous reset, high.
  input wire logic [3:0] mux_channel_in, // Selected channel.
  input wire logic channel_valid_in, // A channel is selected.
  input wire logic convert_in, // Held level being converted.
  output logic [9:0] core_result_out // Converted value.
);
  // settled only while converting.
  // Outside a valid convert phase the output wanders every cycle, so a
  // sequencer that samples at the wrong moment cannot pick up a good value.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      core_result_out <= 10'h3C3;
    end
    else if (convert_in && channel_valid_in)
    begin
      core_result_out <= {mux_channel_in, 6'h2B};
    end
    else
    begin
      core_result_out <= core_result_out + 10'h155;
    end
  end
endmodule : adc_core_model

// file: adc_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/100ps
module adc_conversion_sequencer_bench;
  logic clk_in, srst_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ch_valid, sample, convert;
  logic cv_d;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb, mux_ch;
  logic [1:0] bresp, rresp, resp;
  logic [9:0] port_lines, core_result;
  logic [3:0] ch_q[$];
  int n_mismatch, n_compared, s_cnt, c_cnt, last_s, last_c;

  adc_conversion_sequencer adc_conversion_sequencer_i (
    .clk_in(clk_in), .srst_in(srst_in),
    .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid),
    .axi_awready_out(awready), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
    .axi_wvalid_in(wvalid), .axi_wready_out(wready),
    .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
    .axi_bready_in(bready), .axi_araddr_in(araddr),
    .axi_arvalid_in(arvalid), .axi_arready_out(arready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
    .axi_rready_in(rready), .port_lines_in(port_lines),
    .core_result_in(core_result), .mux_channel_out(mux_ch),
    .channel_valid_out(ch_valid), .sample_out(sample),
    .convert_out(convert));

  adc_core_model adc_core_model_i (
    .clk_in(clk_in), .srst_in(srst_in), .mux_channel_in(mux_ch),
    .channel_valid_in(ch_valid), .convert_in(convert),
    .core_result_out(core_result));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Phase lengths and the channel of every conversion that reaches convert.
  always @(posedge clk_in)
  begin
    cv_d <= convert;
    s_cnt <= sample ? s_cnt + 1 : 0;
    c_cnt <= convert ? c_cnt + 1 : 0;
    if (!sample && s_cnt != 0)
      last_s <= s_cnt;
    if (!convert && c_cnt != 0)
      last_c <= c_cnt;
    if (convert && !cv_d)
      ch_q.push_back(mux_ch);
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [31:0] ctl(input logic s, input logic [1:0] m,
                                      input logic [3:0] c);
    return {24'h0, s, 1'b0, m, c};
  endfunction : ctl

  function automatic logic [31:0] res(input logic [3:0] c);
    return {16'h0, c, 2'b00, c, 6'h2B};
  endfunction : res

  function automatic logic [31:0] stat(input logic o, input logic e);
    return {6'h0, port_lines, 14'h0, o, e};
  endfunction : stat

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    chk(32'h0, 32'h1);
    complete_run();
  endtask : hang

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_in);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (i == 50)
      hang();
  endtask : wr

  task automatic rd(input logic [15:0] a);
    int i;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_in);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (i == 50)
      hang();
  endtask : rd

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_val, exp);
  endtask : rchk

  task automatic go(input logic s, input logic [1:0] m, input logic [3:0] c);
    wr(adc_seq_pkg::CONTROL_OFS, ctl(s, m, c));
  endtask : go

  // Busy is polled through the control register; polling never reads the
  // result, so the unread state is left alone.
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000; i++)
    begin
      rd(adc_seq_pkg::CONTROL_OFS);
      if (rd_val[adc_seq_pkg::BUSY_BIT] === 1'b0)
        break;
    end
    if (i == 2000)
      hang();
  endtask : wait_idle

  task automatic wait_conv(input int n);
    int i;
    for (i = 0; i < 5000 && ch_q.size() < n; i++)
      @(posedge clk_in);
    if (i == 5000)
      hang();
  endtask : wait_conv

  // Channels in conversion order, first in the lowest nibble.
  task automatic chk_q(input logic [31:0] seq, input int n);
    chk(32'(ch_q.size()), 32'(n));
    for (int i = 0; i < n && i < ch_q.size(); i++)
      chk({28'h0, ch_q[i]}, {28'h0, seq[4*i +: 4]});
    ch_q.delete();
  endtask : chk_q

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  initial
  begin
    srst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, cv_d} = 6'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0;
    wstrb = 4'hF;
    port_lines = 10'h2A5;
    {n_mismatch, n_compared, s_cnt, c_cnt, last_s, last_c} = '0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    rchk(adc_seq_pkg::RESULT_OFS, 32'h0);
    rchk(adc_seq_pkg::CONTROL_OFS, 32'h0);
    rchk(16'h0010, 32'h0);
    chk({30'h0, resp}, {30'h0, adc_seq_pkg::RESP_SLVERR});
    wr(16'h0010, 32'h1);
    chk({30'h0, resp}, {30'h0, adc_seq_pkg::RESP_SLVERR});
    wr(adc_seq_pkg::RESULT_OFS, 32'hFFFF);
    rchk(adc_seq_pkg::RESULT_OFS, 32'h0);
    rchk(adc_seq_pkg::STATUS_OFS, stat(1'b0, 1'b0));
    $display("Test reset_values done");
    go(1'b1, 2'h0, 4'h5);
    chk({31'h0, ch_valid}, 32'h1);
    rchk(adc_seq_pkg::CONTROL_OFS, 32'h185);
    wait_idle();
    chk(32'(last_s), 32'(adc_seq_pkg::SAMPLE_CYC));
    chk(32'(last_c), 32'(adc_seq_pkg::CONVERT_CYC));
    rchk(adc_seq_pkg::CONTROL_OFS, 32'h005);
    rchk(adc_seq_pkg::STATUS_OFS, stat(1'b0, 1'b1));
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h5));
    chk_q(32'h5, 1);
    wr(adc_seq_pkg::STATUS_OFS, 32'h3);
    $display("Test single done");
    go(1'b1, 2'h0, 4'h2);
    wait_idle();
    rchk(adc_seq_pkg::STATUS_OFS, stat(1'b0, 1'b1));
    go(1'b1, 2'h0, 4'h3);
    wait_idle();
    rchk(adc_seq_pkg::STATUS_OFS, stat(1'b1, 1'b1));
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h3));
    wr(adc_seq_pkg::STATUS_OFS, 32'h3);
    rchk(adc_seq_pkg::STATUS_OFS, stat(1'b0, 1'b0));
    ch_q.delete();
    $display("Test overrun done");
    go(1'b1, 2'h0, 4'h1);
    repeat (100) @(posedge clk_in);
    go(1'b0, 2'h0, 4'h1);
    rchk(adc_seq_pkg::CONTROL_OFS, 32'h101);
    wait_idle();
    chk_q(32'h1, 1);
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h1));
    $display("Test single_stop_ignored done");
    go(1'b1, 2'h2, 4'h2);
    wait_conv(1);
    go(1'b0, 2'h2, 4'h2);
    wait_idle();
    chk_q(32'h012, 3);
    rchk(adc_seq_pkg::CONTROL_OFS, ctl(1'b0, 2'h2, 4'h2));
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h0));
    $display("Test scan_once done");
    go(1'b1, 2'h1, 4'h4);
    wait_conv(2);
    go(1'b0, 2'h1, 4'h4);
    wait_idle();
    chk_q(32'h44, 2);
    $display("Test single_repeat done");
    go(1'b1, 2'h1, 4'h7);
    wait_conv(1);
    go(1'b1, 2'h0, 4'h8);
    wait_idle();
    chk_q(32'h87, 2);
    rchk(adc_seq_pkg::CONTROL_OFS, ctl(1'b0, 2'h0, 4'h8));
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h8));
    $display("Test deferred_fields done");
    go(1'b1, 2'h3, 4'h1);
    wait_conv(1);
    go(1'b1, 2'h3, 4'h2);
    wait_conv(4);
    go(1'b0, 2'h3, 4'h2);
    wait_idle();
    chk_q(32'h01201, 5);
    $display("Test scan_repeat done");
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h0));
    go(1'b1, 2'h0, 4'h3);
    repeat (10) @(posedge clk_in);
    go(1'b0, 2'h0, 4'h3);
    go(1'b1, 2'h0, 4'h6);
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h0));
    wait_idle();
    chk_q(32'h6, 1);
    rchk(adc_seq_pkg::RESULT_OFS, res(4'h6));
    $display("Test abort done");
    go(1'b1, 2'h0, 4'hC);
    repeat (5) @(posedge clk_in);
    chk({31'h0, ch_valid}, 32'h0);
    wait_idle();
    ch_q.delete();
    $display("Test reserved_channel done");
    complete_run();
  end
endmodule : adc_conversion_sequencer_bench
